// ==== ebc_top.sv ====
// equalizer boost control: pin codes, serial chain and ahb-lite registers
// Function
// R1: pin code is unsigned, first pin most significant
// R2: undriven boost-select pin reads as zero
// R3: mode high allows serial chain programming
// R4: mode low clears registers, uses pin codes
// R5: chain shifts only while enable is low
// R6: serial data sampled on shift clock rising
// R7: serial out is input delayed 21 clocks
// R8: power select low powers channel down
// R9: system drives power select or ties high
// R10: unused serial bus means mode held low
// R11: host shift clock between 10 and 20 MHz; ebc_host drives it at 6.25 MHz
// R12: serial boost value overrides pin code
// R13: 21-bit word applied when enable rises; ebc_top latches only its low 20 bits, the top bit is not applied
// R14: per-channel mux picks pins or serial field
`timescale 1ns/1ps
module ebc_top
  import ebc_pkg::*;
(
  input  wire logic             I_CLK,            // 50 MHz system clock
  input  wire logic             I_SYS_RST,        // async reset, high
  input  wire ebc_pkg::ebc_pins_t I_PINS,         // asynchronous pins
  input  wire logic             I_HSEL,           // ahb slave select
  input  wire logic [31:0]      I_HADDR,          // ahb address
  input  wire logic [1:0]       I_HTRANS,         // ahb transfer type
  input  wire logic             I_HWRITE,         // ahb write
  input  wire logic [2:0]       I_HSIZE,          // ahb size
  input  wire logic [31:0]      I_HWDATA,         // ahb write data
  input  wire logic             I_HREADY,         // ahb bus ready
  output logic                  o_HREADYOUT,      // slave ready
  output logic                  o_HRESP,          // slave response
  output logic [31:0]           o_HRDATA,         // read data
  output ebc_pkg::ebc_boost_t   o_BOOST_LEVEL,    // effective boost
  output logic [3:0]            o_CHANNEL_ACTIVE, // channel powered
  output logic [3:0]            o_INPUT_HIGH_Z,   // channel input hi-z
  output logic                  o_SERIAL_DATA_OUT // chain echo
);
  import ebc_pkg::*;

  // all assertions run on the system clock and rest during reset
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);

  // two-stage synchroniser for every pin, first stage read only by second
  ebc_pins_t                    sync1_q;          // first stage
  ebc_pins_t                    pins_q;           // usable pin levels
  logic                         sclk_prev_q;      // previous shift clock
  logic                         enb_prev_q;       // previous enable_n
  logic [EBC_CHAIN_LEN-1:0]     chain_q;          // serial shift chain
  logic [EBC_CHAIN_LEN-1:0]     chain_d;          // next chain value
  logic [EBC_CHANNELS*EBC_FIELD_W-1:0] applied_q; // applied serial word
  logic [EBC_CHANNELS*EBC_FIELD_W-1:0] applied_d; // next applied word
  ebc_boost_t                   boost_d;          // next effective boost
  logic [3:0]                   active_d;         // next active mask
  logic [3:0]                   ctrl_q;           // software power mask
  logic                         sdo_q;            // serial output flop
  logic [31:0]                  rdata_q;          // read data flop
  logic                         wr_pend_q;        // write data phase due
  logic [7:0]                   wr_addr_q;        // latched write offset

  // named decode terms
  wire logic sclk_rise   = pins_q.shift_clk & ~sclk_prev_q;
  wire logic enb_rise    = pins_q.serial_enable_n & ~enb_prev_q;
  wire logic serial_mode = pins_q.mode;
  wire logic shift_ev    = serial_mode & ~pins_q.serial_enable_n
                           & sclk_rise;
  wire logic apply_ev    = serial_mode & enb_rise;
  wire logic bus_req     = I_HSEL & I_HTRANS[1] & I_HREADY;
  wire logic rd_req      = bus_req & ~I_HWRITE;
  wire logic wr_req      = bus_req & I_HWRITE;
  wire logic [7:0] req_ofs = I_HADDR[7:0];
  wire logic ofs_hit     = (I_HADDR[31:8] == 24'h00_0000);

  // elaboration checks: the chain must carry every field, a pin code
  // must fit in its boost field, and the power mask is four bits wide
  if (EBC_CHANNELS * EBC_FIELD_W > EBC_CHAIN_LEN)
  begin : g_chain_chk
    $error("chain too short for all boost fields");
  end
  if (EBC_CODE_W > EBC_FIELD_W)
  begin : g_code_chk
    $error("pin code wider than boost field");
  end
  if (EBC_CHANNELS != 4)
  begin : g_chan_chk
    $error("power mask and outputs carry four channels");
  end

  // synchroniser and edge history
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      sync1_q     <= '0;
      pins_q      <= '0;
      // enable_n idles high: start both stages there, so no false rise
      sync1_q.serial_enable_n <= 1'b1;
      pins_q.serial_enable_n  <= 1'b1;
      sclk_prev_q <= 1'b0;
      enb_prev_q  <= 1'b1;
    end
    else
    begin
      sync1_q     <= I_PINS;  // undriven pins arrive low via pull-down, see R2
      pins_q      <= sync1_q;
      sclk_prev_q <= pins_q.shift_clk;
      enb_prev_q  <= pins_q.serial_enable_n;
    end
  end

  // chain next value: clear in pin mode, shift on qualified edges
  always_comb
  begin
    chain_d = chain_q;
    if (!serial_mode)
      chain_d = '0;  // see R4
    else if (shift_ev)
      chain_d = {chain_q[EBC_CHAIN_LEN-2:0],
                 pins_q.serial_data_in};  // see R3, see R5, see R6
  end

  // applied word latches the chain when enable rises
  always_comb
  begin
    applied_d = applied_q;
    if (!serial_mode)
      applied_d = '0;  // see R4
    else if (apply_ev)
      applied_d = chain_q[EBC_CHANNELS*EBC_FIELD_W-1:0];  // see R13
  end

  // per-channel source mux and power gating
  always_comb
  begin
    for (int ch = 0; ch < EBC_CHANNELS; ch++)
    begin
      if (serial_mode)
        boost_d[ch] = applied_q[ch*EBC_FIELD_W +: EBC_FIELD_W];  // see R12
      else
        boost_d[ch] = {{(EBC_FIELD_W-EBC_CODE_W){1'b0}},
                       pins_q.boost_select_pins[ch]};  // see R1, see R14
      active_d[ch]  = pins_q.channel_power_select[ch] & ctrl_q[ch];  // see R8
    end
  end

  // serial state and outputs
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      chain_q          <= '0;
      applied_q        <= '0;
      sdo_q            <= 1'b0;
      o_BOOST_LEVEL    <= '0;
      o_CHANNEL_ACTIVE <= 4'h0;
      o_INPUT_HIGH_Z   <= 4'hF;
    end
    else
    begin
      chain_q          <= chain_d;
      applied_q        <= applied_d;
      sdo_q            <= chain_q[EBC_CHAIN_LEN-1];  // see R7
      o_BOOST_LEVEL    <= boost_d;
      o_CHANNEL_ACTIVE <= active_d;
      o_INPUT_HIGH_Z   <= ~active_d;  // see R8
    end
  end

  assign o_SERIAL_DATA_OUT = sdo_q;
  assign o_HREADYOUT       = 1'b1;  // zero wait states
  assign o_HRESP           = 1'b0;  // always okay
  assign o_HRDATA          = rdata_q;

  // read mux for the address phase
  wire logic [31:0] status_w = {24'h00_0000, o_CHANNEL_ACTIVE, 2'b00,
                                pins_q.serial_enable_n, serial_mode};
  wire logic [31:0] rd_mux =
    !ofs_hit                    ? 32'h0000_0000 :
    (req_ofs == EBC_CTRL_OFS)   ? {28'h000_0000, ctrl_q} :
    (req_ofs == EBC_STATUS_OFS) ? status_w :
    (req_ofs == EBC_BOOST_OFS)  ? {12'h000, o_BOOST_LEVEL} :
    (req_ofs == EBC_CHAIN_OFS)  ? {11'h000, chain_q} :
                                  32'h0000_0000;

  // ahb-lite slave: read data and write capture
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      rdata_q   <= EBC_RDATA_RST;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      ctrl_q    <= EBC_CTRL_RST;
    end
    else
    begin
      if (rd_req)
        rdata_q <= rd_mux;
      if (I_HREADY)
      begin
        wr_pend_q <= wr_req & ofs_hit;
        wr_addr_q <= req_ofs;
      end
      if (wr_pend_q && wr_addr_q == EBC_CTRL_OFS)
        ctrl_q <= I_HWDATA[3:0];
    end
  end

  // properties guard the pin mode, the serial chain and power gating
  property p_mode_clear;
    !serial_mode |=> (chain_q == '0) && (applied_q == '0);
  endproperty
  a_mode_clear: assert property (p_mode_clear) // see R4
    else $error("chain not cleared in pin mode");

  property p_shift;
    shift_ev |=> chain_q == {$past(chain_q[EBC_CHAIN_LEN-2:0]),
                             $past(pins_q.serial_data_in)};
  endproperty
  a_shift: assert property (p_shift) // see R6
    else $error("chain did not shift in sampled bit");

  property p_hold_enb;
    serial_mode && pins_q.serial_enable_n ##1 serial_mode
      |-> $stable(chain_q);
  endproperty
  a_hold_enb: assert property (p_hold_enb) // see R5
    else $error("chain changed with enable high");

  property p_serial_prog;
    pins_q.mode && !pins_q.serial_enable_n && $rose(pins_q.shift_clk)
      |=> chain_q[0] == $past(pins_q.serial_data_in);
  endproperty
  a_serial_prog: assert property (p_serial_prog) // see R3
    else $error("serial bit not taken in serial mode");

  property p_apply;
    apply_ev |=> applied_q == $past(chain_q[19:0]);
  endproperty
  a_apply: assert property (p_apply) // see R13
    else $error("applied word not taken on enable rise");

  property p_pin_mux;
    !serial_mode |=> o_BOOST_LEVEL[0] ==
      {2'b00, $past(pins_q.boost_select_pins[0])};
  endproperty
  a_pin_mux: assert property (p_pin_mux) // see R14
    else $error("pin code not selected");

  property p_override;
    serial_mode |=> o_BOOST_LEVEL[3] == $past(applied_q[19:15]);
  endproperty
  a_override: assert property (p_override) // see R12
    else $error("serial field did not override pins");

  property p_power;
    !pins_q.channel_power_select[2] |=>
      !o_CHANNEL_ACTIVE[2] && o_INPUT_HIGH_Z[2];
  endproperty
  a_power: assert property (p_power) // see R8
    else $error("channel not powered down");

  property p_echo;
    shift_ev |=> ##1
      o_SERIAL_DATA_OUT == $past(chain_q[EBC_CHAIN_LEN-2], 2);
  endproperty
  a_echo: assert property (p_echo) // see R7
    else $error("serial out is not chain tail");

  // in serial mode a falling or steady shift clock leaves the chain alone
  property p_rise_only;
    serial_mode && !$rose(pins_q.shift_clk) |=> chain_q == $past(chain_q);
  endproperty
  a_rise_only: assert property (p_rise_only) // see R6
    else $error("chain moved without a rising shift clock");

  // channel 3 pin code, first pin as the most significant digit
  property p_pin_msb;
    !serial_mode |=> o_BOOST_LEVEL[3] ==
      {2'b00, $past(pins_q.boost_select_pins[3])};
  endproperty
  a_pin_msb: assert property (p_pin_msb) // see R1
    else $error("channel 3 pin code not taken msb first");

  // pin high and mask bit set keeps a channel powered
  property p_power_up;
    pins_q.channel_power_select[1] && ctrl_q[1] |=>
      o_CHANNEL_ACTIVE[1] && !o_INPUT_HIGH_Z[1];
  endproperty
  a_power_up: assert property (p_power_up) // see R8
    else $error("channel not active with power select high");

  // in serial mode the applied word only moves on a closing enable edge
  property p_applied_hold;
    serial_mode && !apply_ev |=> applied_q == $past(applied_q);
  endproperty
  a_applied_hold: assert property (p_applied_hold) // see R13
    else $error("applied word changed without enable rise");

  // pin mode empties the chain, so the serial output stays low
  property p_clear_echo;
    !serial_mode ##1 !serial_mode |=> !o_SERIAL_DATA_OUT;
  endproperty
  a_clear_echo: assert property (p_clear_echo) // see R4
    else $error("serial output not quiet in pin mode");

endmodule // ebc_top

// ==== ebc_pkg.sv ====
// package for the equalizer boost control block: constants and types
package ebc_pkg;
  localparam int          EBC_CHANNELS     = 4;      // equalizer channels
  localparam int          EBC_CODE_W       = 3;      // pin code digits
  localparam int          EBC_FIELD_W      = 5;      // serial boost field
  localparam int          EBC_CHAIN_LEN    = 21;     // serial chain length
  localparam int          EBC_SYNC_STAGES  = 2;      // synchroniser depth
  // register byte offsets
  localparam logic [7:0]  EBC_CTRL_OFS     = 8'h00;  // power mask, rw
  localparam logic [7:0]  EBC_STATUS_OFS   = 8'h04;  // synced mode and enable_n levels, active channels, ro
  localparam logic [7:0]  EBC_BOOST_OFS    = 8'h08;  // effective boost, ro
  localparam logic [7:0]  EBC_CHAIN_OFS    = 8'h0C;  // shift chain, ro
  // field positions
  localparam int          EBC_ST_MODE_POS  = 0;      // synced mode level
  localparam int          EBC_ST_ENB_POS   = 1;      // synced enable_n
  localparam int          EBC_ST_ACT_POS   = 4;      // active channels
  // reset values
  localparam logic [3:0]  EBC_CTRL_RST     = 4'hF;   // all channels allowed
  localparam logic [31:0] EBC_RDATA_RST    = 32'h0000_0000;

  // pins that arrive from outside the clock domain
  typedef struct packed {
    logic [EBC_CHANNELS-1:0][EBC_CODE_W-1:0] boost_select_pins;
    logic [EBC_CHANNELS-1:0]                 channel_power_select;
    logic                                    mode;
    logic                                    serial_enable_n;
    logic                                    shift_clk;
    logic                                    serial_data_in;
  } ebc_pins_t;

  // effective boost level per channel
  typedef logic [EBC_CHANNELS-1:0][EBC_FIELD_W-1:0] ebc_boost_t;
endpackage

// ==== ebc_host.sv ====
// host model that drives the serial boost programming pins
`timescale 1ns/1ps
module ebc_host (
  input  wire logic i_clk,       // bench clock paces the frame
  output logic      o_shift_clk, // link clock, still between frames
  output logic      o_enable_n,  // frame enable, active low
  output logic      o_data       // serial data, pulled low when idle
);
  // idle bus: clock low, enable high, data at its pull-down level
  initial
  begin
    o_shift_clk = 1'b0;
    o_enable_n  = 1'b1;
    o_data      = 1'b0;
  end

  // one 21-bit frame, w[20] first; en low keeps enable high
  task automatic frame(input logic [20:0] w, input logic en);
    @(posedge i_clk) o_enable_n <= ~en;
    for (int i = 20; i >= 0; i--)
    begin
      @(posedge i_clk) o_data <= w[i];
      repeat (3) @(posedge i_clk);
      o_shift_clk <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_shift_clk <= 1'b0;
    end
    repeat (4) @(posedge i_clk);
    o_enable_n <= 1'b1;
    o_data     <= 1'b0;
  endtask
endmodule // ebc_host

// ==== test_equalizer_boost_control.sv ====
// self-checking bench for the equalizer boost control block
`timescale 1ns/1ps
module test_equalizer_boost_control;
  import ebc_pkg::*;
  logic             I_CLK, rst, hsel, hwrite, mode, hrdy, resp, sdo;
  logic [1:0]       htrans;
  logic [31:0]      haddr, hwdata, rdata, r;
  logic [3:0][2:0]  code;     // pin codes per channel
  logic [3:0]       pwr, act, hz, mask;
  logic             sck, enb_n, sdi;
  logic [15:0]      seed;     // lfsr state
  logic [20:0]      w;        // serial word
  bit               chain_m[$]; // model chain, oldest bit first
  ebc_pins_t        pins;
  ebc_boost_t       boost;
  int               bad_count, compares;

  assign pins = {code, pwr, mode, enb_n, sck, sdi};

  ebc_host ebc_host_i (.i_clk(I_CLK), .o_shift_clk(sck),
    .o_enable_n(enb_n), .o_data(sdi));

  ebc_top ebc_top_i (.I_CLK(I_CLK), .I_SYS_RST(rst), .I_PINS(pins),
    .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
    .I_HREADY(hrdy), .o_HREADYOUT(hrdy), .o_HRESP(resp),
    .o_HRDATA(rdata), .o_BOOST_LEVEL(boost), .o_CHANNEL_ACTIVE(act),
    .o_INPUT_HIGH_Z(hz), .o_SERIAL_DATA_OUT(sdo));

  // clock at 50 MHz
  initial
  begin
    I_CLK = 1'b0;
    forever #10 I_CLK = ~I_CLK;
  end

  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // expected boost in pin mode: zero-extended code per channel
  function automatic logic [31:0] pin_boost();
    logic [31:0] e;
    e = '0;
    for (int k = 0; k < 4; k++)
      e[5*k +: 5] = {2'b00, code[k]};
    return e;
  endfunction

  // chain model: push each enabled bit, keep the newest 21
  task automatic model_frame(input logic [20:0] v, input logic en);
    for (int i = 20; i >= 0; i--)
      if (en)
        chain_m.push_back(v[i]);
    while (chain_m.size() > 21)
      void'(chain_m.pop_front());
  endtask

  // expected chain register: oldest kept bit sits at the top
  function automatic logic [31:0] chain_exp();
    logic [31:0] e;
    e = '0;
    foreach (chain_m[k])
      e[chain_m.size() - 1 - k] = chain_m[k];
    return e;
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask

  // single ahb-lite word transfer
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge I_CLK);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge I_CLK); while (hrdy !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge I_CLK); while (hrdy !== 1'b1);
    rd = rdata;
  endtask

  task automatic settle();
    repeat (6) @(posedge I_CLK);
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // watchdog
  initial
  begin
    #400000;
    bad_count++;
    test_done();
  end

  initial
  begin
    rst       = 1'b1;
    hsel      = 1'b0;
    hwrite    = 1'b0;
    htrans    = 2'h0;
    haddr     = '0;
    hwdata    = '0;
    code      = '0;
    pwr       = '0;    // power selects follow reset
    mode      = 1'b0;  // no serial use yet: mode low
    seed      = 16'h000B;
    bad_count = 0;
    compares  = 0;
    repeat (4) @(posedge I_CLK);
    rst <= 1'b0;
    ahb(1'b0, EBC_CTRL_OFS, '0, r);
    chk(r, {28'h0, EBC_CTRL_RST});
    chk({31'h0, resp}, 32'h0);
    chk({31'h0, hrdy}, 32'h1);
    $display("test reset done");
    // pin codes and power selects under random values
    for (int n = 0; n < 8; n++)
    begin
      seed = nx(seed);
      code <= seed[11:0];
      pwr  <= seed[15:12];
      settle();
      chk({12'h0, boost}, pin_boost());
      chk({24'h0, hz, act}, {24'h0, ~pwr, pwr});
    end
    mask = 4'h5;
    ahb(1'b1, EBC_CTRL_OFS, {28'h0, mask}, r);
    pwr <= 4'hF;
    settle();
    chk({28'h0, act}, {28'h0, mask});
    ahb(1'b1, EBC_CTRL_OFS, 32'hF, r);
    $display("test pins done");
    // serial frames override the pin codes
    mode <= 1'b1;
    settle();
    for (int n = 0; n < 2; n++)
    begin
      seed = nx(seed);
      w = {seed[4:0], seed};
      ebc_host_i.frame(w, 1'b1);
      model_frame(w, 1'b1);
      settle();
      chk({12'h0, boost}, {12'h0, w[19:0]});
      chk({31'h0, sdo}, {31'h0, w[20]});
      ahb(1'b0, EBC_CHAIN_OFS, '0, r);
      chk(r, chain_exp());
      ahb(1'b0, EBC_BOOST_OFS, '0, r);
      chk(r, {12'h0, w[19:0]});
    end
    ahb(1'b0, EBC_STATUS_OFS, '0, r);
    chk(r, {24'h0, pwr, 2'b00, enb_n, mode});
    ebc_host_i.frame(~w, 1'b0);
    model_frame(~w, 1'b0);
    settle();
    ahb(1'b0, EBC_CHAIN_OFS, '0, r);
    chk(r, chain_exp());
    ahb(1'b0, 8'h10, '0, r);
    chk(r, 32'h0);
    $display("test serial done");
    // mode low clears the chain and returns to pin codes
    mode <= 1'b0;
    settle();
    ahb(1'b0, EBC_CHAIN_OFS, '0, r);
    chk(r, 32'h0);
    chk({12'h0, boost}, pin_boost());
    chk({31'h0, sdo}, 32'h0);
    ahb(1'b0, EBC_BOOST_OFS, '0, r);
    chk(r, pin_boost());
    $display("test clear done");
    test_done();
  end
endmodule // test_equalizer_boost_control
